// *** eab_ctrl.sv ***
// Purpose: external area bus controller, cycle sequencer and pin driver
// Assumes: cpu holds request, address, size and write data until done
// Notes:   pin wait modes are treated as program wait; no wait pin here
`timescale 1ns/100ps
// What this block does
// [R1] per-area bus width 8 or 16 bits
// [R2] data access 2 or 3 states
// [R3] 3-state access inserts 0..3 program waits
// [R4] internal accesses bypass area configuration
// [R5] basic area uses area 1 settings
// [R6] three 64k areas with own settings
// [R7] ram off merges ram window into basic
// [R8] reset gives normal 3-state external space
// [R9] multiplex: address and data never together
// [R10] multiplex address cycle is 2 states
// [R11] address cycle wait from address wait bit
// [R12] chip select active with per-area polarity
// [R13] chip select pins always driven, no software enable
// [R14] strobe or hold output, shared polarity
// [R15] 16 address outputs, always driven, no direction enable
// [R16] multiplex address placement follows width
// [R17] 8-bit area uses upper lane only
// [R18] 8-bit splits word and longword into bytes
// [R19] address cycle width matches area width
// [R20] wait mode decode, only with 3 states
// [R21] 16-bit byte lane by parity, long is two words
// [R22] write strobes per lane, one read strobe
// [R23] program waits between second and third states
// [R24] only external areas start cycles
module eab_ctrl
  import eab_pkg::*;
(
  input  wire logic        i_ref_clk,          // system clock
  input  wire logic        i_reset,            // async reset, active high
  // cpu side
  input  wire logic        i_req,              // access request, level
  input  wire logic        i_write,            // 1 write, 0 read
  input  wire logic [1:0]  i_size,             // byte, word, long
  input  wire logic [23:0] i_addr,             // internal address
  input  wire logic [31:0] i_wdata,            // write data, msb first
  output logic [31:0]      o_rdata,            // read data
  output logic             o_done,             // access finished, pulse
  output logic             o_internal,         // request not external
  // configuration
  input  wire logic [7:0]  i_area1_cfg,        // area control byte 1
  input  wire logic [7:0]  i_area2_cfg,        // area control byte 2
  input  wire logic [7:0]  i_area3_cfg,        // area control byte 3
  input  wire logic        i_strobe_polarity_bit,
  input  wire logic        i_multiplex_bus_enable,
  input  wire logic        i_onchip_ram_enable,
  // external pins
  output logic             o_area1_chip_select,
  output logic             o_area2_chip_select,
  output logic             o_area3_chip_select,
  output logic             o_address_strobe,   // strobe or hold
  output logic [15:0]      o_addr,             // address lines
  output logic [15:0]      o_data_out,         // data or mux lines out
  output logic [15:0]      o_data_oe,          // per-line drive enable
  input  wire logic [15:0] i_data_in,          // data or mux lines in
  output logic             o_read_strobe_n,
  output logic             o_upper_write_strobe_n,
  output logic             o_lower_write_strobe_n
);
  eab_state_t state_q, state_d;       // sequencer state
  logic [1:0]  area_q;                // latched area
  logic [1:0]  wait_q;                // remaining waits
  logic [1:0]  part_q;                // sub-access index
  logic [31:0] rdata_q;               // assembled read data
  logic        done_q;                // finish pulse
  logic [7:0]  cfg_q;                 // latched area config

  // decoder instance
  logic       ext_hit;
  logic [1:0] hit_area;
  eab_decode u_dec (
    .i_addr       (i_addr),
    .i_ram_enable (i_onchip_ram_enable),
    .o_external   (ext_hit),
    .o_area       (hit_area)
  );

  // pick config for decoded area
  wire [7:0] hit_cfg = (hit_area == 2'd2) ? i_area2_cfg :
                       (hit_area == 2'd3) ? i_area3_cfg : i_area1_cfg;
  assign o_internal = i_req && !ext_hit;                    // [R4]

  // fields of the latched config, and the live multiplex enable
  wire is8   = cfg_q[EAB_F_WIDTH];                          // [R1]
  wire ast3  = cfg_q[EAB_F_AST];
  wire aw    = cfg_q[EAB_F_AW];
  wire [1:0] wms = {cfg_q[EAB_F_WMS1], cfg_q[EAB_F_WMS0]};
  wire [1:0] wc  = {cfg_q[EAB_F_WC1], cfg_q[EAB_F_WC0]};
  wire mux   = i_multiplex_bus_enable;

  // data wait count decode
  function automatic logic [1:0] data_waits(input logic a3,
                                            input logic [1:0] m,
                                            input logic [1:0] c);
    if (!a3)
      data_waits = 2'd0;                                    // [R2]
    else if (m == EAB_WM_NONE)
      data_waits = 2'd0;                                    // [R20]
    else
      data_waits = c;                                       // [R3]
  endfunction

  // number of sub-accesses minus one
  wire [1:0] parts = is8 ? ((i_size == EAB_SZ_LONG) ? 2'd3 :      // [R18]
                            (i_size == EAB_SZ_WORD) ? 2'd1 : 2'd0) :
                           ((i_size == EAB_SZ_LONG) ? 2'd1 : 2'd0); // [R21]
  wire last_part = (part_q == parts);

  // current byte/word address
  wire [23:0] cur_addr = is8 ? (i_addr + {22'd0, part_q}) :
                         (i_addr + {21'd0, part_q, 1'b0});
  wire byte16 = !is8 && (i_size == EAB_SZ_BYTE);
  wire odd    = cur_addr[0];
  wire use_hi = is8 || !byte16 || !odd;                     // [R21]
  wire use_lo = !is8 && (!byte16 || odd);                   // [R17]

  // write data slice for this sub-access
  wire [7:0]  wbyte = (i_size == EAB_SZ_BYTE) ? i_wdata[7:0] :
                      (i_size == EAB_SZ_WORD) ?
                        (part_q[0] ? i_wdata[7:0] : i_wdata[15:8]) :
                        i_wdata[31 - 8*part_q -: 8];
  wire [15:0] wword = (i_size == EAB_SZ_LONG) ?
                        (part_q[0] ? i_wdata[15:0] : i_wdata[31:16]) :
                        i_wdata[15:0];
  wire [15:0] wlanes = is8 ? {wbyte, 8'h00} :               // [R17]
                       byte16 ? (odd ? {8'h00, i_wdata[7:0]} :
                                       {i_wdata[7:0], 8'h00}) : wword;

  wire in_adr  = (state_q == EAB_ADR1) || (state_q == EAB_ADR2) ||
                 (state_q == EAB_ADRW);
  wire in_data = (state_q == EAB_DT1) || (state_q == EAB_DT2) ||
                 (state_q == EAB_DTW) || (state_q == EAB_DT3);
  wire data_end = (state_q == EAB_DT3) ||
                  ((state_q == EAB_DT2) && !ast3);
  wire start = i_req && ext_hit && !done_q;                 // [R24]

  // next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      EAB_IDLE: if (start) state_d = mux ? EAB_ADR1 : EAB_DT1;
      EAB_ADR1: state_d = EAB_ADR2;                         // [R10]
      EAB_ADR2: state_d = aw ? EAB_ADRW : EAB_DT1;          // [R11]
      EAB_ADRW: state_d = EAB_DT1;
      EAB_DT1:  state_d = EAB_DT2;
      EAB_DT2: begin
        if (!ast3)
          state_d = last_part ? EAB_IDLE : (mux ? EAB_ADR1 : EAB_DT1);
        else if (wait_q != 2'd0)
          state_d = EAB_DTW;                                // [R23]
        else
          state_d = EAB_DT3;
      end
      EAB_DTW:  if (wait_q == 2'd1) state_d = EAB_DT3;
      EAB_DT3:  state_d = last_part ? EAB_IDLE :
                          (mux ? EAB_ADR1 : EAB_DT1);       // [R18]
    endcase
  end

  // state and area latch; reset = area defaults, normal 3-state
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= EAB_IDLE;
      area_q  <= EAB_AREA_NONE;
      cfg_q   <= EAB_AREA_RST;                              // [R8]
    end else begin
      state_q <= state_d;
      if (state_q == EAB_IDLE && start) begin
        area_q <= hit_area;                                 // [R24]
        cfg_q  <= hit_cfg;
      end else if (state_d == EAB_IDLE) begin
        area_q <= EAB_AREA_NONE;
      end
    end
  end

  // wait counter loads at first data state
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset)
      wait_q <= 2'd0;
    else if (state_q == EAB_DT1)
      wait_q <= data_waits(ast3, wms, wc);                  // [R3]
    else if (state_q == EAB_DTW)
      wait_q <= wait_q - 2'd1;
  end

  // sub-access index and read assembly
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      part_q  <= 2'd0;
      rdata_q <= 32'h0000_0000;
      done_q  <= 1'b0;
    end else begin
      done_q <= data_end && last_part;
      if (data_end && !i_write) begin
        if (is8)
          rdata_q <= {rdata_q[23:0], i_data_in[15:8]};      // [R17]
        else if (byte16)
          rdata_q <= {24'h00_0000,
                      odd ? i_data_in[7:0] : i_data_in[15:8]};
        else
          rdata_q <= {rdata_q[15:0], i_data_in};
      end
      if (data_end)
        part_q <= last_part ? 2'd0 : part_q + 2'd1;
    end
  end
  assign o_rdata = rdata_q;
  assign o_done  = done_q;

  // chip selects active while area accessed
  wire busy = (state_q != EAB_IDLE);
  wire cs1 = busy && (area_q == 2'd1);
  wire cs2 = busy && (area_q == 2'd2);
  wire cs3 = busy && (area_q == 2'd3);
  assign o_area1_chip_select = cs1 ^ !i_area1_cfg[EAB_F_CSPOL]; // [R12]
  assign o_area2_chip_select = cs2 ^ !i_area2_cfg[EAB_F_CSPOL];
  assign o_area3_chip_select = cs3 ^ !i_area3_cfg[EAB_F_CSPOL];

  // strobe in normal mode, hold in first address state in mux mode
  wire strobe = mux ? (state_q == EAB_ADR1) : in_data;      // [R14]
  assign o_address_strobe = strobe ^ !i_strobe_polarity_bit;

  // address lines; multiplex places address on shared lines
  assign o_addr = cur_addr[15:0];                           // [R15]
  wire [15:0] mux_addr = is8 ? {cur_addr[7:0], 8'h00} :     // [R16]
                         cur_addr[15:0];
  wire [15:0] mux_oe   = is8 ? 16'hFF00 : 16'hFFFF;         // [R19]
  wire [15:0] lane_oe  = {{8{use_hi}}, {8{use_lo}}};
  wire wr_data = in_data && i_write;

  // shared lines carry address or data, never both
  assign o_data_out = (mux && in_adr) ? mux_addr : wlanes;  // [R9]
  assign o_data_oe  = (mux && in_adr) ? mux_oe :
                      (wr_data ? lane_oe : 16'h0000);

  // strobes in second data state onward
  // strobe must still stand in the last state, where read data is taken
  wire strb = (state_q == EAB_DT2) || (state_q == EAB_DTW) ||
              (state_q == EAB_DT3);
  assign o_read_strobe_n        = !(strb && !i_write);      // [R22]
  assign o_upper_write_strobe_n = !(strb && i_write && use_hi);
  assign o_lower_write_strobe_n = !(strb && i_write && use_lo);
endmodule

// *** eab_pkg.sv ***
// Purpose: shared constants for the external area bus controller
// Assumes: 24-bit internal address, 16-bit external data path
// Notes:   area configuration byte layout matches the per-area control byte
package eab_pkg;
  // area decode bounds
  localparam logic [23:0] EAB_BASIC_LO  = 24'h08_0000;
  localparam logic [23:0] EAB_BASIC_HI  = 24'hFB_FFFF;
  localparam logic [23:0] EAB_AREA1_LO  = 24'hFC_0000;
  localparam logic [23:0] EAB_AREA2_LO  = 24'hFD_0000;
  localparam logic [23:0] EAB_AREA3_LO  = 24'hFE_0000;
  localparam logic [23:0] EAB_AREA_SIZE = 24'h01_0000;
  localparam logic [23:0] EAB_RAM_LO    = 24'hFF_0000;
  localparam logic [23:0] EAB_RAM_HI    = 24'hFF_9FFF;
  // area control byte field positions
  localparam int EAB_F_WIDTH = 7;
  localparam int EAB_F_AST   = 6;
  localparam int EAB_F_CSPOL = 5;
  localparam int EAB_F_AW    = 4;
  localparam int EAB_F_WMS1  = 3;
  localparam int EAB_F_WMS0  = 2;
  localparam int EAB_F_WC1   = 1;
  localparam int EAB_F_WC0   = 0;
  // area control byte reset value
  localparam logic [7:0] EAB_AREA_RST = 8'hD3;
  // wait mode codes
  localparam logic [1:0] EAB_WM_PROG  = 2'h0;
  localparam logic [1:0] EAB_WM_NONE  = 2'h1;
  localparam logic [1:0] EAB_WM_PIN   = 2'h2;
  localparam logic [1:0] EAB_WM_AUTO  = 2'h3;
  // access sizes
  localparam logic [1:0] EAB_SZ_BYTE = 2'h0;
  localparam logic [1:0] EAB_SZ_WORD = 2'h1;
  localparam logic [1:0] EAB_SZ_LONG = 2'h2;
  // area indices (0 = none)
  localparam logic [1:0] EAB_AREA_NONE = 2'h0;

  // bus cycle states, gray codes along the usual path
  typedef enum logic [2:0] {
    EAB_IDLE = 3'b000,
    EAB_ADR1 = 3'b001,
    EAB_ADR2 = 3'b011,
    EAB_ADRW = 3'b010,
    EAB_DT1  = 3'b110,
    EAB_DT2  = 3'b111,
    EAB_DTW  = 3'b101,
    EAB_DT3  = 3'b100
  } eab_state_t;
endpackage

// *** eab_decode.sv ***
// Purpose: address decode to area and external flag
// Assumes: address stable while request is held
// Notes:   combinational only
`timescale 1ns/100ps
module eab_decode
  import eab_pkg::*;
(
  input  wire logic [23:0] i_addr,        // internal address
  input  wire logic        i_ram_enable,  // on-chip ram enable
  output logic             o_external,    // address is external space
  output logic [1:0]       o_area         // 0 none, 1..3 area, basic maps to 1
);
  // range compares
  wire in_basic = (i_addr >= EAB_BASIC_LO) && (i_addr <= EAB_BASIC_HI);
  wire in_a1 = (i_addr >= EAB_AREA1_LO) && (i_addr < EAB_AREA2_LO);
  wire in_a2 = (i_addr >= EAB_AREA2_LO) && (i_addr < EAB_AREA3_LO);
  wire in_a3 = (i_addr >= EAB_AREA3_LO) &&
               (i_addr < (EAB_AREA3_LO + EAB_AREA_SIZE));
  // ram window merges into basic when ram is off
  wire in_ram = !i_ram_enable &&
                (i_addr >= EAB_RAM_LO) && (i_addr <= EAB_RAM_HI);

  assign o_external = in_basic || in_a1 || in_a2 || in_a3 || in_ram; // [R24]
  // basic and merged ram use area 1 settings
  assign o_area = in_a2 ? 2'd2 :                                     // [R6]
                  in_a3 ? 2'd3 :
                  (in_a1 || in_basic || in_ram) ? 2'd1 :             // [R5] [R7]
                  EAB_AREA_NONE;
endmodule

// *** eab_ctrl_asserts.sv ***
// Purpose: pin level checks for the external area bus controller
// Assumes: one clock domain, asynchronous active high reset
// Notes:   the chip select at active level selects the area settings
`timescale 1ns/100ps
module eab_ctrl_asserts
  import eab_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  input  wire logic        i_req,
  input  wire logic        i_write,
  input  wire logic [1:0]  i_size,
  input  wire logic        o_done,
  input  wire logic        o_internal,
  input  wire logic [7:0]  i_area1_cfg,
  input  wire logic [7:0]  i_area2_cfg,
  input  wire logic [7:0]  i_area3_cfg,
  input  wire logic        i_strobe_polarity_bit,
  input  wire logic        i_multiplex_bus_enable,
  input  wire logic        o_area1_chip_select,
  input  wire logic        o_area2_chip_select,
  input  wire logic        o_area3_chip_select,
  input  wire logic        o_address_strobe,
  input  wire logic [15:0] o_addr,
  input  wire logic        o_read_strobe_n,
  input  wire logic        o_upper_write_strobe_n,
  input  wire logic        o_lower_write_strobe_n
);
  logic [2:0] cs_on;  // chip selects at their active level
  logic [7:0] cfg;    // settings of the area being accessed
  logic       rd;     // read strobe asserted
  logic       wr;     // any write strobe asserted
  logic       as_on;  // strobe or hold at active level
  // active level follows each area polarity bit
  assign cs_on = {o_area3_chip_select == i_area3_cfg[EAB_F_CSPOL],
                  o_area2_chip_select == i_area2_cfg[EAB_F_CSPOL],
                  o_area1_chip_select == i_area1_cfg[EAB_F_CSPOL]};
  assign cfg = cs_on[2] ? i_area3_cfg : (cs_on[1] ? i_area2_cfg : i_area1_cfg);
  assign rd = !o_read_strobe_n;
  assign wr = !(o_upper_write_strobe_n && o_lower_write_strobe_n);
  assign as_on = o_address_strobe == i_strobe_polarity_bit;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // strobe held through second state, three waits and last state
  sequence low5_s;
    rd [*5] ##1 !rd;
  endsequence
  strobe_dir_a: assert property ((rd || wr) |-> (wr == i_write) && !(rd && wr))
    else $error("strobe does not match direction");
  cs_single_a: assert property ($onehot0(cs_on))
    else $error("more than one chip select active");
  cs_during_a: assert property ((rd || wr) |-> cs_on != 3'h0)
    else $error("strobe without chip select");
  internal_idle_a: assert property (i_req && o_internal |-> !rd && !wr && !o_done)
    else $error("bus cycle on internal address");
  narrow_lane_a: assert property (wr && cfg[EAB_F_WIDTH] |-> o_lower_write_strobe_n)
    else $error("lower lane used by 8-bit area");
  wide_byte_a: assert property (wr && !cfg[EAB_F_WIDTH] && i_size == EAB_SZ_BYTE
    |-> o_upper_write_strobe_n == o_addr[0] && o_lower_write_strobe_n == !o_addr[0])
    else $error("byte lane does not follow parity");
  short_strobe_a: assert property ($fell(o_read_strobe_n) && !cfg[EAB_F_AST]
    |=> !rd)
    else $error("wait inserted where none allowed");
  no_wait_a: assert property ($fell(o_read_strobe_n) && cfg[EAB_F_AST]
    && cfg[3:2] == EAB_WM_NONE |=> rd ##1 !rd)
    else $error("wait inserted in wait prohibited mode");
  wait_three_a: assert property ($fell(o_read_strobe_n) && cfg[EAB_F_AST]
    && cfg[3:2] != EAB_WM_NONE && cfg[1:0] == 2'h3 |-> low5_s)
    else $error("three program waits not inserted");
  mux_apart_a: assert property (i_multiplex_bus_enable && as_on |-> !rd && !wr)
    else $error("address hold overlaps data strobe");
  normal_as_a: assert property (!i_multiplex_bus_enable && (rd || wr) |-> as_on)
    else $error("address strobe missing in data state");
endmodule
bind eab_ctrl eab_ctrl_asserts i_chk (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
  .i_req(i_req), .i_write(i_write), .i_size(i_size), .o_done(o_done),
  .o_internal(o_internal), .i_area1_cfg(i_area1_cfg),
  .i_area2_cfg(i_area2_cfg), .i_area3_cfg(i_area3_cfg),
  .i_strobe_polarity_bit(i_strobe_polarity_bit),
  .i_multiplex_bus_enable(i_multiplex_bus_enable),
  .o_area1_chip_select(o_area1_chip_select),
  .o_area2_chip_select(o_area2_chip_select),
  .o_area3_chip_select(o_area3_chip_select),
  .o_address_strobe(o_address_strobe), .o_addr(o_addr),
  .o_read_strobe_n(o_read_strobe_n),
  .o_upper_write_strobe_n(o_upper_write_strobe_n),
  .o_lower_write_strobe_n(o_lower_write_strobe_n));

// *** eab_ext_mem.sv ***
// Purpose: external byte device model on the controller pins
// Assumes: read byte is the low address byte xor 0x5A
// Notes:   released lines show the inverse of the last value
`timescale 1ns/100ps
module eab_ext_mem (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  input  wire logic        i_wide,
  input  wire logic        i_mux,
  input  wire logic        i_as_on,
  input  wire logic        i_read_strobe_n,
  input  wire logic        i_upper_write_strobe_n,
  input  wire logic        i_lower_write_strobe_n,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_data_out,
  output logic [15:0]      o_data_in,
  output logic [31:0]      o_wlog,
  output logic [7:0]       o_wcnt
);
  logic [7:0]  adr_q;   // low address byte taken in address cycle
  logic [7:0]  a;       // byte address in use
  logic [15:0] last_q;  // last value on the lines
  logic        wr;      // any write strobe low
  logic        wr_q;    // write strobe seen last cycle
  assign a = i_mux ? adr_q : i_addr[7:0];
  assign wr = !(i_upper_write_strobe_n && i_lower_write_strobe_n);
  // even byte on upper lane for a wide device
  assign o_data_in = !i_read_strobe_n ?
    {(i_wide ? {a[7:1], 1'b0} : a) ^ 8'h5A, {a[7:1], 1'b1} ^ 8'h5A} : ~last_q;
  // latch address, log written bytes high lane first
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      {adr_q, last_q, wr_q, o_wlog, o_wcnt} <= '0;
    end else begin
      last_q <= o_data_in;
      wr_q <= wr;
      if (i_as_on && i_mux) begin
        adr_q <= i_wide ? i_data_out[7:0] : i_data_out[15:8];
      end
      if (wr && !wr_q && !i_upper_write_strobe_n && !i_lower_write_strobe_n) begin
        o_wlog <= {o_wlog[15:0], i_data_out};
        o_wcnt <= o_wcnt + 8'h02;
      end else if (wr && !wr_q) begin
        o_wlog <= {o_wlog[23:0], i_upper_write_strobe_n ? i_data_out[7:0] : i_data_out[15:8]};
        o_wcnt <= o_wcnt + 8'h01;
      end
    end
  end
endmodule

// *** eab_ctrl_bench.sv ***
// Purpose: self-checking bench for the external area bus controller
// Assumes: inputs driven at the falling clock edge
// Notes:   each table row is written and then read back
`timescale 1ns/100ps
module eab_ctrl_bench;
  import eab_pkg::*;
  localparam logic [7:0] T_CFG [7] = '{8'hD3, 8'h00, 8'h83, 8'h47, 8'h4A, 8'hDD, 8'h20};
  localparam logic [23:0] T_ADR [7] = '{24'hFC_0000, 24'hFD_0010, 24'hFE_0020,
    24'h08_0000, 24'hFF_0101, 24'hFD_0042, 24'hFE_0044};
  localparam logic [1:0] T_SZ [7] = '{EAB_SZ_BYTE, EAB_SZ_WORD, EAB_SZ_LONG,
    EAB_SZ_LONG, EAB_SZ_BYTE, EAB_SZ_WORD, EAB_SZ_BYTE};
  localparam logic [6:0] T_MUX = 7'h60;  // rows in multiplex mode
  localparam logic [6:0] T_RAM = 7'h6F;  // rows with on-chip ram on
  logic        i_ref_clk = 0, i_reset = 1, i_req = 0, i_write = 0, sp = 0;
  logic        mux = 0, ram = 1, done, intl, cs1, cs2, cs3, as, rdn, uwn, lwn;
  logic [1:0]  i_size = EAB_SZ_BYTE;
  logic [23:0] i_addr = 24'h00_0000;
  logic [31:0] i_wdata = 32'hA1B2_C3D4, rdata, wlog, ed, msk;
  logic [7:0]  c, cfg1 = 8'hD3, cfg2 = 8'hD3, cfg3 = 8'hD3, wcnt, cnt0;
  logic [15:0] oaddr, dout, doe, din;
  int          fail_count = 0, comparisons = 0, cycles = 0, lat, n, w, per, dn;
  eab_ctrl i_dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_req(i_req),
    .i_write(i_write), .i_size(i_size), .i_addr(i_addr), .i_wdata(i_wdata),
    .o_rdata(rdata), .o_done(done), .o_internal(intl), .i_area1_cfg(cfg1),
    .i_area2_cfg(cfg2), .i_area3_cfg(cfg3), .i_strobe_polarity_bit(sp),
    .i_multiplex_bus_enable(mux), .i_onchip_ram_enable(ram),
    .o_area1_chip_select(cs1), .o_area2_chip_select(cs2),
    .o_area3_chip_select(cs3), .o_address_strobe(as), .o_addr(oaddr),
    .o_data_out(dout), .o_data_oe(doe), .i_data_in(din), .o_read_strobe_n(rdn),
    .o_upper_write_strobe_n(uwn), .o_lower_write_strobe_n(lwn));
  eab_ext_mem i_mem (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_wide(!c[7]),
    .i_mux(mux), .i_as_on(as == sp), .i_read_strobe_n(rdn),
    .i_upper_write_strobe_n(uwn), .i_lower_write_strobe_n(lwn), .i_addr(oaddr),
    .i_data_out(dout), .o_data_in(din), .o_wlog(wlog), .o_wcnt(wcnt));
  // clock at 20 MHz
  always #25 i_ref_clk = ~i_ref_clk;
  // cut a hang short
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // one access, cycles counted until the done pulse
  task automatic access(input logic wr, input logic [1:0] sz, input logic [23:0] a);
    @(negedge i_ref_clk);
    {i_write, i_size, i_addr, i_req} = {wr, sz, a, 1'b1};
    lat = 0;
    while (lat < 80) begin
      @(negedge i_ref_clk);
      lat++;
      if (done === 1'b1) break;
    end
    i_req = 0;
  endtask
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // main sequence: reset, table rows, internal addresses
  initial begin
    c = 8'hD3;
    repeat (6) @(posedge i_ref_clk);
    @(negedge i_ref_clk) i_reset = 0;
    for (int k = 0; k < 7; k++) begin
      c = T_CFG[k];
      {cfg1, cfg2, cfg3} = {3{8'hD3}};
      if (T_ADR[k][23:16] == 8'hFD) cfg2 = c;
      else if (T_ADR[k][23:16] == 8'hFE) cfg3 = c;
      else cfg1 = c;
      {mux, ram, sp} = {T_MUX[k], T_RAM[k], k[0]};
      n = (T_SZ[k] == EAB_SZ_BYTE) ? 1 : ((T_SZ[k] == EAB_SZ_WORD) ? 2 : 4);
      w = (c[6] && c[3:2] != EAB_WM_NONE) ? int'(c[1:0]) : 0;
      per = (c[6] ? 3 + w : 2) + (mux ? 2 + int'(c[4]) : 0);
      msk = (n == 4) ? 32'hFFFF_FFFF : (32'h0000_0001 << (8 * n)) - 32'h0000_0001;
      ed = 32'h0000_0000;
      for (int i = 0; i < n; i++) ed = {ed[23:0], (T_ADR[k][7:0] + 8'(i)) ^ 8'h5A};
      cnt0 = wcnt;
      access(1'b1, T_SZ[k], T_ADR[k]);
      check(32'(lat), 32'((c[7] ? n : (n + 1) / 2) * per + 1), "write time");
      check(32'(wcnt - cnt0), 32'(n), "bytes written");
      check(wlog & msk, i_wdata & msk, "write data");
      access(1'b0, T_SZ[k], T_ADR[k]);
      check(32'(lat), 32'((c[7] ? n : (n + 1) / 2) * per + 1), "read time");
      check(rdata & msk, ed, "read data");
    end
    // ram window with ram on, then a low internal address
    ram = 1;
    for (int k = 0; k < 2; k++) begin
      @(negedge i_ref_clk);
      {i_addr, i_write, i_req} = {k ? 24'h00_0100 : 24'hFF_0100, 2'b01};
      dn = 0;
      repeat (8) @(negedge i_ref_clk) dn += int'(done === 1'b1);
      check({31'h0, intl}, 32'h0000_0001, "internal flag");
      check(32'(dn), 32'h0000_0000, "internal done");
      i_req = 0;
    end
    finish_test();
  end
endmodule
